// ===== agcl_amp_model.sv
// behavioural stepped-gain amplifier that latches the gain word on a strobe edge
module agcl_amp_model (
  input  wire logic        clk_i,
  input  wire logic [2:0]  word_i,
  input  wire logic        strobe_i,
  output logic [2:0]       gain_o,
  output logic signed [5:0] gain_db_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic strobe_q = 1'b0;
  // any strobe edge latches, so a held-high strobe after init keeps the first word
  always @(posedge clk_i) begin
    if (strobe_i !== strobe_q) gain_o <= word_i;
    strobe_q <= strobe_i;
  end
  always_comb gain_db_o = $signed({3'h0, gain_o}) * 6'sh06 - 6'sh0c;
endmodule

// ===== agcl_float_code.sv
// fixed to float conversion of detected power into exponent and mantissa
module agcl_float_code (
  input  wire logic [agcl_pkg::POWER_W-1:0] power_i,
  output logic [agcl_pkg::CODE_W-1:0]       code_o
);
  logic found;

  always_comb begin
    found  = 1'b0;
    code_o = {3'h0, power_i[1:0]};
    for (int b = agcl_pkg::POWER_W - 1; b >= 2; b--) begin
      if (!found && power_i[b]) begin
        found  = 1'b1;
        code_o = {3'(b - 1), power_i[b-1 -: 2]};
      end
    end
  end
endmodule

// ===== agcl_gain_loop.sv
// two-channel gain control loop with wishbone register access
module agcl_gain_loop #(
  parameter int SAMPLE_W = 10
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic [9:0]          wb_adr_i,
  input  wire logic [31:0]         wb_dat_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic                wb_we_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic                sync_in_n_i,
  input  wire logic [SAMPLE_W-1:0] sample_a_i,
  input  wire logic [SAMPLE_W-1:0] sample_b_i,
  output logic [2:0]               analog_gain_word_a_o,
  output logic [2:0]               analog_gain_word_b_o,
  output logic                     chan_a_gain_strobe_o,
  output logic                     chan_b_gain_strobe_o,
  output logic [2:0]               digital_gain_code_a_o,
  output logic [2:0]               digital_gain_code_b_o
);
  localparam int AW = agcl_pkg::ACC_W;
  localparam int EW = agcl_pkg::ERR_W;
  localparam int WW = agcl_pkg::WORD_W;
  localparam logic [AW-1:0] ACC_MAX = {AW{1'b1}};

  // the detector clamps into nine bits; samples narrower than 2 or wider than 16 bits make no sense
  if (SAMPLE_W < 2 || SAMPLE_W > 16) begin : g_bad_width
    $error("sample width out of range");
  end

  // ---------------- sync-in pin synchroniser
  logic sync_meta, sync_q;
  logic sync_active;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_meta <= 1'b1;
      sync_q    <= 1'b1;
    end else begin
      sync_meta <= sync_in_n_i;
      sync_q    <= sync_meta;
    end
  end

  assign sync_active = !sync_q;

  // ---------------- register file
  logic [7:0] loop_ctrl, next_loop_ctrl;
  logic [7:0] det_ctrl, next_det_ctrl;
  logic [7:0] preset [2];
  logic [7:0] next_preset [2];
  logic [7:0] table_mem [agcl_pkg::TABLE_N];
  logic [7:0] next_table_mem [agcl_pkg::TABLE_N];
  logic       next_ack;
  logic [31:0] next_dat;
  logic [7:0]  req_idx;
  logic        wr_fire;
  logic [AW-1:0] acc [2];

  function automatic logic is_table(input logic [7:0] idx);
    return idx >= agcl_pkg::IDX_TABLE_BASE && idx <= agcl_pkg::IDX_TABLE_LAST;
  endfunction

  function automatic logic [4:0] table_slot(input logic [7:0] idx);
    return 5'(idx - agcl_pkg::IDX_TABLE_BASE);
  endfunction

  assign req_idx = wb_adr_i[9:2];
  // write lands on the edge where the master sees ack
  assign wr_fire = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];

  always_comb begin
    next_ack       = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_dat       = wb_dat_o;
    next_loop_ctrl = loop_ctrl;
    next_det_ctrl  = det_ctrl;
    next_preset    = preset;
    next_table_mem = table_mem;
    if (next_ack) begin
      next_dat = 32'h0;
      if (!wb_we_i) begin
        if (is_table(req_idx)) begin
          next_dat[7:0] = table_mem[table_slot(req_idx)];
        end else begin
          unique case (req_idx)
            agcl_pkg::IDX_LOOP_CTRL:  next_dat[7:0] = loop_ctrl;
            agcl_pkg::IDX_PRESET_A:   next_dat[7:0] = preset[0];
            agcl_pkg::IDX_PRESET_B:   next_dat[7:0] = preset[1];
            agcl_pkg::IDX_READBACK_A: next_dat[7:0] = acc[0][AW-1 -: 8];
            agcl_pkg::IDX_READBACK_B: next_dat[7:0] = acc[1][AW-1 -: 8];
            agcl_pkg::IDX_DET_DELAY:  next_dat[7:0] = det_ctrl;
            default:                  next_dat[7:0] = 8'h00;
          endcase
        end
      end
    end
    if (wr_fire) begin
      if (is_table(req_idx)) begin
        next_table_mem[table_slot(req_idx)] = wb_dat_i[7:0];
      end else begin
        unique case (req_idx)
          agcl_pkg::IDX_LOOP_CTRL: next_loop_ctrl = wb_dat_i[7:0] & 8'h38;
          agcl_pkg::IDX_PRESET_A:  next_preset[0] = wb_dat_i[7:0];
          agcl_pkg::IDX_PRESET_B:  next_preset[1] = wb_dat_i[7:0];
          agcl_pkg::IDX_DET_DELAY: next_det_ctrl  = wb_dat_i[7:0] & 8'h7f;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0;
      loop_ctrl <= agcl_pkg::LOOP_CTRL_RST;
      det_ctrl  <= agcl_pkg::DET_DELAY_RST;
      preset    <= '{default: agcl_pkg::PRESET_RST};
      table_mem <= '{default: 8'h00};
    end else begin
      wb_ack_o  <= next_ack;
      wb_dat_o  <= next_dat;
      loop_ctrl <= next_loop_ctrl;
      det_ctrl  <= next_det_ctrl;
      preset    <= next_preset;
      table_mem <= next_table_mem;
    end
  end

  // ---------------- per-channel loop
  logic [1:0] loop_shift;
  logic       hold;
  logic [1:0] comb_order;
  logic [4:0] align_delay;
  logic [SAMPLE_W-1:0] samples [2];
  logic [WW-1:0] word [2];
  logic          strobe [2];
  logic [WW-1:0] dig_code [2];

  assign loop_shift  = loop_ctrl[agcl_pkg::LOOP_SHIFT_LSB +: 2];
  assign hold        = loop_ctrl[agcl_pkg::HOLD_BIT];
  assign comb_order  = det_ctrl[agcl_pkg::COMB_ORDER_LSB +: 2];
  assign align_delay = det_ctrl[agcl_pkg::ALIGN_LSB +: 5];
  assign samples[0]  = sample_a_i;
  assign samples[1]  = sample_b_i;

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic [agcl_pkg::POWER_W-1:0] power;
    logic                         power_valid;
    logic [agcl_pkg::CODE_W-1:0]  code;
    logic signed [EW-1:0]         err;
    logic signed [AW+1:0]         step, sum;
    logic [AW-1:0]                next_acc;
    logic                         next_strobe;
    logic [WW-1:0]                pipe [agcl_pkg::ALIGN_N];
    logic [WW-1:0]                next_pipe [agcl_pkg::ALIGN_N];
    logic [WW-1:0]                next_code;

    agcl_power_detector #(
      .SAMPLE_W (SAMPLE_W)
    ) u_detector (
      .clk_i         (clk_i),
      .rst_i         (rst_i),
      .sample_i      (samples[ch]),
      .comb_order_i  (comb_order),
      .power_o       (power),
      .power_valid_o (power_valid)
    );

    agcl_float_code u_float (
      .power_i (power),
      .code_o  (code)
    );

    assign err = table_mem[code];

    // fractional bits below the 11-bit integrator give the 2^(shift-8) gain
    always_comb begin
      step     = (AW+2)'(err) <<< loop_shift;
      sum      = $signed({2'b00, acc[ch]}) + step;
      next_acc = acc[ch];
      if (sync_active || hold) begin
        next_acc = {preset[ch], {(AW-8){1'b0}}};
      end else if (power_valid) begin
        if (sum < 0) begin
          next_acc = '0;
        end else if (sum > $signed({2'b00, ACC_MAX})) begin
          next_acc = ACC_MAX;
        end else begin
          next_acc = AW'(sum);
        end
      end
      // strobe looks only at its own channel's word
      if (sync_active) begin
        next_strobe = 1'b1;
      end else if (next_acc[AW-1 -: WW] != acc[ch][AW-1 -: WW]) begin
        next_strobe = !strobe[ch];
      end else begin
        next_strobe = strobe[ch];
      end
    end

    // digital gain code is the inverted word, delayed to line up with the analog step
    always_comb begin
      next_pipe    = pipe;
      next_pipe[0] = ~acc[ch][AW-1 -: WW];
      for (int i = 1; i < agcl_pkg::ALIGN_N; i++) begin
        next_pipe[i] = pipe[i-1];
      end
      next_code = pipe[align_delay];
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        acc[ch]      <= '0;
        strobe[ch]   <= 1'b1;
        pipe         <= '{default: '0};
        dig_code[ch] <= '0;
      end else begin
        acc[ch]      <= next_acc;
        strobe[ch]   <= next_strobe;
        pipe         <= next_pipe;
        dig_code[ch] <= next_code;
      end
    end

    assign word[ch] = acc[ch][AW-1 -: WW];
  end

  assign analog_gain_word_a_o  = word[0];
  assign analog_gain_word_b_o  = word[1];
  assign chan_a_gain_strobe_o  = strobe[0];
  assign chan_b_gain_strobe_o  = strobe[1];
  assign digital_gain_code_a_o = dig_code[0];
  assign digital_gain_code_b_o = dig_code[1];
endmodule

// ===== agcl_gain_loop_checker.sv
// port assertions for the gain loop
module agcl_gain_loop_checker (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       sync_in_n_i,
  input wire logic [2:0] analog_gain_word_a_o,
  input wire logic [2:0] analog_gain_word_b_o,
  input wire logic       chan_a_gain_strobe_o,
  input wire logic       chan_b_gain_strobe_o
);
  logic [3:0] sync_hist;
  logic [3:0] next_sync_hist;
  logic       quiet;
  always_comb next_sync_hist = {sync_hist[2:0], sync_in_n_i};
  always_ff @(posedge clk_i) sync_hist <= next_sync_hist;
  // strobe rules only apply once sync-in has left the synchroniser
  always_comb quiet = (&sync_hist) & sync_in_n_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence sync_low4;
    !sync_in_n_i [*4];
  endsequence
  sequence req_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  chk_reset_strobe_high:
    assert property (disable iff (1'b0) rst_i |=> chan_a_gain_strobe_o && chan_b_gain_strobe_o)
    else $error("strobe low after reset edge");
  chk_sync_strobe_high:
    assert property (sync_low4 |=> chan_a_gain_strobe_o && chan_b_gain_strobe_o)
    else $error("strobe low during sync");
  chk_strobe_quiet_a:
    assert property (quiet && $changed(chan_a_gain_strobe_o) |-> $changed(analog_gain_word_a_o))
    else $error("strobe a toggled without word change");
  chk_strobe_quiet_b:
    assert property (quiet && $changed(chan_b_gain_strobe_o) |-> $changed(analog_gain_word_b_o))
    else $error("strobe b toggled without word change");
  chk_strobe_follow_a:
    assert property (quiet && $changed(analog_gain_word_a_o) |-> $changed(chan_a_gain_strobe_o))
    else $error("word a changed without strobe");
  chk_strobe_follow_b:
    assert property (quiet && $changed(analog_gain_word_b_o) |-> $changed(chan_b_gain_strobe_o))
    else $error("word b changed without strobe");
  chk_strobe_indep_b:
    assert property (quiet && $changed(analog_gain_word_a_o) && $stable(analog_gain_word_b_o)
                     |-> $stable(chan_b_gain_strobe_o))
    else $error("strobe b moved with channel a");
  chk_strobe_indep_a:
    assert property (quiet && $changed(analog_gain_word_b_o) && $stable(analog_gain_word_a_o)
                     |-> $stable(chan_a_gain_strobe_o))
    else $error("strobe a moved with channel b");
  chk_word_spacing:
    assert property (quiet && $changed(analog_gain_word_a_o) |=> $stable(analog_gain_word_a_o) [*7])
    else $error("word a changed twice within eight clocks");
  chk_ack_latency:
    assert property (req_taken |=> wb_ack_o)
    else $error("no ack one cycle after request");
  chk_ack_single:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule

bind agcl_gain_loop agcl_gain_loop_checker u_chk (
  .clk_i               (clk_i),
  .rst_i               (rst_i),
  .wb_cyc_i            (wb_cyc_i),
  .wb_stb_i            (wb_stb_i),
  .wb_ack_o            (wb_ack_o),
  .sync_in_n_i         (sync_in_n_i),
  .analog_gain_word_a_o(analog_gain_word_a_o),
  .analog_gain_word_b_o(analog_gain_word_b_o),
  .chan_a_gain_strobe_o(chan_a_gain_strobe_o),
  .chan_b_gain_strobe_o(chan_b_gain_strobe_o)
);

// ===== agcl_gain_loop_test.sv
// self-checking bench for the gain loop with an amplifier model on channel a
module agcl_gain_loop_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic [9:0]        adr = 10'h000;
  logic [31:0]       dat = 32'h0;
  logic              we = 1'b0;
  logic              cyc = 1'b0;
  logic              stb = 1'b0;
  logic              sync_n = 1'b1;
  logic [9:0]        sa = 10'h000;
  logic [9:0]        sb = 10'h000;
  logic [31:0]       rdat;
  logic              ack;
  logic [2:0]        word_a;
  logic [2:0]        word_b;
  logic              stra;
  logic              strb;
  logic [2:0]        gain_a;
  logic signed [5:0] db_a;
  logic [2:0]        dig_a;
  logic [2:0]        dig_b;
  int                failures = 0;
  int                num_checks = 0;

  always #20 clk_i = ~clk_i;

  agcl_gain_loop #(.SAMPLE_W(10)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sync_in_n_i(sync_n), .sample_a_i(sa), .sample_b_i(sb), .analog_gain_word_a_o(word_a),
    .analog_gain_word_b_o(word_b), .chan_a_gain_strobe_o(stra), .chan_b_gain_strobe_o(strb),
    .digital_gain_code_a_o(dig_a), .digital_gain_code_b_o(dig_b));
  agcl_amp_model amp_a (.clk_i(clk_i), .word_i(word_a), .strobe_i(stra), .gain_o(gain_a), .gain_db_o(db_a));

  task automatic stop_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    num_checks++;
    if (got !== want) begin
      failures++;
      $display("ERROR t=%0t got=%h want=%h", $time, got, want);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {idx, 2'h0};
    dat <= {24'h0, d};
    // ack and read data are taken at the rising edge; only the watchdog ends a stuck wait
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] want);
    logic [7:0] q;
    xfer(1'b0, idx, 8'h00, q);
    chk(q, want);
  endtask

  function automatic logic [4:0] fcode(input int p);
    int e;
    if (p < 4) return p[4:0];
    e = 2;
    while ((p >> (e + 1)) != 0) e++;
    return {3'(e - 1), 2'((p >> (e - 2)) & 3)};
  endfunction

  task automatic t_reset();
    repeat (11) @(posedge clk_i);
    @(negedge clk_i);
    chk({6'h0, stra, strb}, 8'h03);
    chk({2'h0, word_a, word_b}, 8'h00);
    @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  task automatic t_regs();
    rd(agcl_pkg::IDX_LOOP_CTRL, agcl_pkg::LOOP_CTRL_RST);
    rd(agcl_pkg::IDX_PRESET_A, agcl_pkg::PRESET_RST);
    rd(agcl_pkg::IDX_DET_DELAY, agcl_pkg::DET_DELAY_RST);
    rd(agcl_pkg::IDX_READBACK_A, 8'h00);
    wr(agcl_pkg::IDX_DET_DELAY, 8'hff);
    rd(agcl_pkg::IDX_DET_DELAY, 8'h7f);
    wr(agcl_pkg::IDX_LOOP_CTRL, 8'hff);
    rd(agcl_pkg::IDX_LOOP_CTRL, 8'h38);
    wr(agcl_pkg::IDX_READBACK_B, 8'h55);
    rd(agcl_pkg::IDX_READBACK_B, 8'h00);
    rd(8'h20, 8'h00);
    wr(8'h85, 8'h9c);
    rd(8'h85, 8'h9c);
    wr(8'h85, 8'h00);
  endtask

  // one target entry, all others zero, so only the right code moves the loop
  task automatic run_code(input int x, input logic [1:0] sh, input logic [1:0] comb, output logic [7:0] q);
    wr(agcl_pkg::IDX_TABLE_BASE + 8'(fcode(x)), 8'h7f);
    wr(agcl_pkg::IDX_DET_DELAY, {6'h00, comb});
    wr(agcl_pkg::IDX_LOOP_CTRL, {2'h0, sh, 4'h8});
    sa <= 10'(x);
    sb <= 10'(x);
    repeat (64) @(posedge clk_i);
    wr(agcl_pkg::IDX_LOOP_CTRL, {2'h0, sh, 4'h0});
    repeat (64) @(posedge clk_i);
    xfer(1'b0, agcl_pkg::IDX_READBACK_A, 8'h00, q);
    wr(agcl_pkg::IDX_LOOP_CTRL, 8'h38);
    wr(agcl_pkg::IDX_TABLE_BASE + 8'(fcode(x)), 8'h00);
  endtask

  task automatic t_code();
    int         xs[9] = '{2, 7, 13, 22, 45, 100, 200, 300, 511};
    logic [7:0] q;
    wr(agcl_pkg::IDX_PRESET_A, 8'h00);
    foreach (xs[i]) begin
      run_code(xs[i], 2'h3, 2'(i % 3), q);
      chk(8'(q >= 8'h03 && q <= 8'h04), 8'h01);
    end
    run_code(200, 2'h0, 2'h0, q);
    chk(q, 8'h00);
  endtask

  task automatic t_sat();
    logic a0;
    logic b0;
    sa <= 10'h1ff;
    sb <= 10'h000;
    wr(agcl_pkg::IDX_TABLE_BASE + 8'h1f, 8'h7f);
    wr(agcl_pkg::IDX_PRESET_B, 8'h00);
    repeat (64) @(posedge clk_i);
    a0 = stra;
    b0 = strb;
    wr(agcl_pkg::IDX_PRESET_A, 8'hff);
    repeat (8) @(posedge clk_i);
    chk({5'h0, word_a}, 8'h07);
    chk({6'h0, stra, strb}, {6'h0, ~a0, b0});
    chk({5'h0, gain_a}, 8'h07);
    chk(8'(db_a), 8'h1e);
    chk({2'h0, dig_a, dig_b}, 8'h07);
    rd(agcl_pkg::IDX_READBACK_A, 8'hff);
    wr(agcl_pkg::IDX_LOOP_CTRL, 8'h30);
    repeat (64) @(posedge clk_i);
    rd(agcl_pkg::IDX_READBACK_A, 8'hff);
    wr(agcl_pkg::IDX_TABLE_BASE + 8'h1f, 8'h80);
    wr(agcl_pkg::IDX_PRESET_A, 8'h02);
    wr(agcl_pkg::IDX_LOOP_CTRL, 8'h38);
    wr(agcl_pkg::IDX_LOOP_CTRL, 8'h30);
    repeat (64) @(posedge clk_i);
    rd(agcl_pkg::IDX_READBACK_A, 8'h00);
    chk({5'h0, word_a}, 8'h00);
  endtask

  task automatic t_sync();
    logic b0;
    wr(agcl_pkg::IDX_PRESET_B, 8'ha0);
    sync_n <= 1'b0;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    chk({6'h0, stra, strb}, 8'h03);
    @(posedge clk_i);
    sync_n <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk({5'h0, word_b}, 8'h05);
    // channel b word moves alone, its strobe must toggle; strobe a is not checked
    b0 = strb;
    wr(agcl_pkg::IDX_PRESET_B, 8'h40);
    wr(agcl_pkg::IDX_LOOP_CTRL, 8'h38);
    repeat (4) @(posedge clk_i);
    chk({5'h0, word_b}, 8'h02);
    chk({7'h0, strb}, {7'h0, ~b0});
  endtask

  initial begin
    t_reset();
    t_regs();
    t_code();
    t_sat();
    t_sync();
    stop_test();
  end

  // whole sequence needs about 1800 clocks
  initial begin
    repeat (8000) @(posedge clk_i);
    failures++;
    stop_test();
  end
endmodule

// ===== agcl_pkg.sv
// constants and register map of the per-channel automatic gain control loop
// Operation
// - each channel drives a 3-bit gain word in 6 dB steps plus one strobe
// - strobe toggles only in a cycle where the gain word changed
// - channel strobes are independent; one channel never toggles the other
// - strobes are asserted while master reset or sync-in is active
// - detector: absolute value, then 2-stage comb-integrator decimating by eight
// - comb order 1 or 2 adds extra comb filtering; 0 keeps plain filter
// - 9-bit detector output becomes a 5-bit code: 3 exponent, 2 mantissa
// - exponent follows leading one: bit 2 gives 001, up to 111
// - mantissa is two bits below leading one; inputs 0-3 map directly
// - code addresses a host-written 32x8 table giving the signed loop error
// - error scaled by two to the power of loop shift minus eight
// - 11-bit integrator saturates at 0 and 2047; top three bits are gain
// - hold high keeps integrator at host preset; low lets loop run
// - top eight integrator bits readable per channel
// - comb order: 0 plain, 1 adds two-tap comb, 2 adds four-tap comb
package agcl_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_LOOP_CTRL  = 8'h14;
  localparam logic [7:0] IDX_PRESET_A   = 8'h17;
  localparam logic [7:0] IDX_PRESET_B   = 8'h18;
  localparam logic [7:0] IDX_READBACK_A = 8'h19;
  localparam logic [7:0] IDX_READBACK_B = 8'h1a;
  localparam logic [7:0] IDX_TABLE_BASE = 8'h80;
  localparam logic [7:0] IDX_TABLE_LAST = 8'h9f;
  localparam logic [7:0] IDX_DET_DELAY  = 8'hf9;
  // loop control fields
  localparam int LOOP_SHIFT_LSB = 4;
  localparam int HOLD_BIT       = 3;
  // detector delay control fields
  localparam int COMB_ORDER_LSB = 0;
  localparam int ALIGN_LSB      = 2;
  // reset values
  localparam logic [7:0] LOOP_CTRL_RST = 8'h00;
  localparam logic [7:0] PRESET_RST    = 8'h00;
  localparam logic [7:0] DET_DELAY_RST = 8'h00;
  // datapath sizes and counts
  localparam int POWER_W   = 9;
  localparam int CODE_W    = 5;
  localparam int TABLE_N   = 32;
  localparam int ERR_W     = 8;
  localparam int INTEG_W   = 11;
  localparam int FRAC_W    = 8;
  localparam int ACC_W     = INTEG_W + FRAC_W;
  localparam int WORD_W    = 3;
  localparam int DECIM     = 8;
  localparam int CIC_GROW  = 6;
  localparam int ALIGN_N   = 32;
  localparam logic [2:0] PHASE_LAST = 3'h7;
  localparam logic [1:0] COMB_ONE   = 2'h1;
  localparam logic [1:0] COMB_FOUR  = 2'h2;
endpackage

// ===== agcl_power_detector.sv
// power detector: magnitude, decimate-by-eight comb-integrator, optional extra comb
module agcl_power_detector #(
  parameter int SAMPLE_W = 10
) (
  input  wire logic                             clk_i,
  input  wire logic                             rst_i,
  input  wire logic signed [SAMPLE_W-1:0]       sample_i,
  input  wire logic [1:0]                       comb_order_i,
  output logic [agcl_pkg::POWER_W-1:0]          power_o,
  output logic                                  power_valid_o
);
  localparam int AW = agcl_pkg::POWER_W + agcl_pkg::CIC_GROW;
  localparam int PW = agcl_pkg::POWER_W;

  if (SAMPLE_W < 2 || SAMPLE_W > 16) begin : g_bad_width
    $error("sample width out of range");
  end

  logic [SAMPLE_W-1:0] mag;
  logic [PW-1:0]       mag9;
  logic [2:0]          phase, next_phase;
  logic [AW-1:0]       integ1, integ2, dly1, diff1d;
  logic [AW-1:0]       next_integ1, next_integ2, next_dly1, next_diff1d;
  logic [AW-1:0]       diff1, diff2;
  logic [PW-1:0]       raw;
  logic [PW-1:0]       hist [3];
  logic [PW-1:0]       next_hist [3];
  logic [PW+1:0]       sum4;
  logic [PW:0]         sum2;
  logic [PW-1:0]       next_power;
  logic                next_valid;

  // magnitude clamps anything above nine bits to full scale; at SAMPLE_W 10 that is only the most negative code
  always_comb begin
    mag  = sample_i[SAMPLE_W-1] ? SAMPLE_W'(-sample_i) : sample_i;
    mag9 = (SAMPLE_W > PW && (mag >> PW) != '0) ? {PW{1'b1}} : PW'(mag);
  end

  always_comb begin
    next_phase  = phase + 3'h1;
    next_integ1 = integ1 + AW'(mag9);
    next_integ2 = integ2 + integ1;
    next_dly1   = dly1;
    next_diff1d = diff1d;
    next_hist   = hist;
    next_power  = power_o;
    next_valid  = 1'b0;
    diff1       = integ2 - dly1;
    diff2       = diff1 - diff1d;
    raw         = diff2[AW-1 -: PW];
    sum2        = {1'b0, raw} + {1'b0, hist[0]};
    sum4        = {2'b0, raw} + {2'b0, hist[0]} + {2'b0, hist[1]} + {2'b0, hist[2]};
    if (phase == agcl_pkg::PHASE_LAST) begin
      next_dly1    = integ2;
      next_diff1d  = diff1;
      next_hist[0] = raw;
      next_hist[1] = hist[0];
      next_hist[2] = hist[1];
      next_valid   = 1'b1;
      unique case (comb_order_i)
        agcl_pkg::COMB_ONE:  next_power = sum2[PW:1];
        agcl_pkg::COMB_FOUR: next_power = sum4[PW+1:2];
        default:             next_power = raw;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase         <= 3'h0;
      integ1        <= '0;
      integ2        <= '0;
      dly1          <= '0;
      diff1d        <= '0;
      hist          <= '{default: '0};
      power_o       <= '0;
      power_valid_o <= 1'b0;
    end else begin
      phase         <= next_phase;
      integ1        <= next_integ1;
      integ2        <= next_integ2;
      dly1          <= next_dly1;
      diff1d        <= next_diff1d;
      hist          <= next_hist;
      power_o       <= next_power;
      power_valid_o <= next_valid;
    end
  end
endmodule
